// >>> rtl/ipsec_opt_pkg.sv
package ipsec_opt_pkg;
	// options byte, both directions
	localparam int OPT_TUNNEL = 0;
	localparam int OPT_IPV6 = 1;
	localparam int OPT_ESN = 4;
	// options byte, encapsulation
	localparam int ENC_PREPEND = 2;
	localparam int ENC_HDR_PDB = 3;
	localparam int ENC_IV_RNG = 5;
	localparam int ENC_CKSM = 7;
	// options byte, decapsulation
	localparam int DEC_LEN_ADJ = 2;
	localparam int DEC_PDU_ONLY = 3;
	localparam int DEC_CKSM = 5;
	localparam int DEC_WIN_LSB = 6;
	// header-manipulation field bits and reserved bits 27:24 within word 0
	localparam int HMO_ROLL_OR_DSC = 28;
	localparam int HMO_HOP_COUNT_DECREMENT = 29;
	localparam int HMO_DFC_OR_DFV = 30;
	localparam int HMO_RSV_OR_ODF = 31;
	localparam int W0_RSV_LSB = 24;
	localparam int W0_RSV_MSB = 27;
	// replay window sizes
	localparam logic [7:0] WIN_NONE = 8'h00;
	localparam logic [7:0] WIN_32 = 8'h20;
	localparam logic [7:0] WIN_64 = 8'h40;
	localparam logic [7:0] WIN_128 = 8'h80;
	// pad length byte plus next-header byte
	localparam logic [15:0] TRAILER_FIXED = 16'h0002;
	localparam logic [15:0] DF_MASK = 16'h4000;
	// controller register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PDB0 = 8'h08;
	localparam logic [7:0] REG_HI_SEQ = 8'h0C;
	localparam logic [7:0] REG_LO_SEQ = 8'h10;
	localparam logic [7:0] REG_FRAME_SEQ = 8'h14;
	localparam logic [7:0] REG_HDR = 8'h18;
	localparam logic [7:0] REG_CKSUM = 8'h1C;
	localparam logic [7:0] REG_FRAME = 8'h20;
	localparam logic [7:0] REG_RES_HDR = 8'h24;
	localparam logic [7:0] REG_RES_LEN = 8'h28;
	localparam logic [7:0] REG_STEER = 8'h2C;
	localparam logic [7:0] REG_SCORE0 = 8'h30;
	localparam int SCORE_WORDS = 4;

	typedef enum logic [1:0] {ERR_NONE, ERR_PDB, ERR_SEQ, ERR_TTL} err_t;

	typedef struct packed {
		logic icvHighSeq;
		logic omitHighSeq;
		logic hdrFromPdb;
		logic prependHdr;
		logic ipv6;
		logic tunnel;
		logic ivFromRng;
		logic cksumOn;
		logic pduOnly;
		logic lenAdjust;
		logic dfCopied;
		logic dfForced;
	} steer_t;
endpackage

// >>> rtl/ipsec_opt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ipsec_opt_if;
	logic start;
	logic encap;
	logic [31:0] pdbWord0;
	logic [31:0] highSeq;
	logic [31:0] lowSeq;
	logic [31:0] frameSeq;
	logic [7:0] ttlIn;
	logic dfInner;
	logic dfHdr;
	logic [15:0] cksumIn;
	logic [7:0] hdrLen;
	logic [15:0] frameLen;
	logic [7:0] padLen;
	logic busy;
	logic done;
	ipsec_opt_pkg::err_t err;
	logic seqWrite;
	logic [31:0] highSeqOut;
	logic [31:0] lowSeqOut;
	logic [7:0] ttlOut;
	logic dfOut;
	logic [15:0] cksumOut;
	logic [15:0] outLen;
	logic [7:0] winSize;
	ipsec_opt_pkg::steer_t steer;
	modport dev(input start, encap, pdbWord0, highSeq, lowSeq, frameSeq, ttlIn, dfInner,
		dfHdr, cksumIn, hdrLen, frameLen, padLen, output busy, done, err, seqWrite,
		highSeqOut, lowSeqOut, ttlOut, dfOut, cksumOut, outLen, winSize, steer);
	modport ctl(output start, encap, pdbWord0, highSeq, lowSeq, frameSeq, ttlIn, dfInner,
		dfHdr, cksumIn, hdrLen, frameLen, padLen, input busy, done, err, seqWrite,
		highSeqOut, lowSeqOut, ttlOut, dfOut, cksumOut, outLen, winSize, steer);
endinterface
`default_nettype wire

// >>> rtl/seq_advance.sv
`timescale 1ns/1ps
`default_nettype none
module seq_advance #(
	parameter int W = 32
) (
	input wire logic [W-1:0] lowIn,
	input wire logic [W-1:0] highIn,
	input wire logic useHigh,
	output logic [W-1:0] lowOut,
	output logic [W-1:0] highOut,
	output logic wrap
);
	logic [W:0] lowSum;
	logic [W:0] highSum;

	// the high word only counts when it extends the sequence
	assign lowSum = {1'b0, lowIn} + {{W{1'b0}}, 1'b1};
	assign highSum = {1'b0, highIn} + {{W{1'b0}}, lowSum[W]};
	assign lowOut = lowSum[W-1:0];
	assign highOut = useHigh ? highSum[W-1:0] : highIn;
	assign wrap = useHigh ? highSum[W] : lowSum[W];
endmodule
`default_nettype wire

// >>> rtl/ipsec_esp_pdb_option_handler.sv
`timescale 1ns/1ps
`default_nettype none
module ipsec_esp_pdb_option_handler (
	input wire logic clk,
	input wire logic rstn,
	ipsec_opt_if.dev link,
	output ipsec_opt_pkg::steer_t pathSteer,
	output logic [7:0] pathWin
);
	import ipsec_opt_pkg::*;

	typedef enum logic [1:0] {IDLE, EVAL} st_t;

	typedef struct packed {
		st_t st;
		logic encap;
		logic [31:0] w0;
		logic [31:0] hi;
		logic [31:0] lo;
		logic [31:0] fseq;
		logic [7:0] ttl;
		logic dfInner;
		logic dfHdr;
		logic [15:0] ck;
		logic [7:0] hl;
		logic [15:0] flen;
		logic [7:0] pad;
		logic done;
		err_t err;
		logic seqWr;
		logic [31:0] hiOut;
		logic [31:0] loOut;
		logic [7:0] ttlOut;
		logic dfOut;
		logic [15:0] ckOut;
		logic [15:0] lenOut;
		logic [7:0] win;
		steer_t steer;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// ----------------------------------------------------------------
	// checksum helper
	// ----------------------------------------------------------------
	// incremental one's-complement update for a changed 16-bit header word;
	// avoids re-reading the whole header from memory
	function automatic logic [15:0] csAdj(input logic [15:0] hc, input logic [15:0] oldW,
		input logic [15:0] newW);
		logic [17:0] sum;
		sum = {2'b00, ~hc} + {2'b00, ~oldW} + {2'b00, newW};
		sum = {2'b00, sum[15:0]} + {16'h0000, sum[17:16]};
		sum = {2'b00, sum[15:0]} + {16'h0000, sum[17:16]};
		return ~sum[15:0];
	endfunction

	// ----------------------------------------------------------------
	// option decode
	// ----------------------------------------------------------------
	logic [7:0] opt;
	logic [3:0] header_manipulation_field;
	logic enc;
	logic esnOn;
	logic ipv6;
	logic tunnel;
	logic dfcOk;
	logic pdbErr;
	logic ttlErr;
	logic seqErr;
	err_t errNow;
	logic [31:0] loInc;
	logic [31:0] hiInc;
	logic wrap;
	logic [7:0] ttlNew;
	logic dfNew;
	logic csOn;
	logic [15:0] ckTtl;
	logic [15:0] ckDf;
	logic [15:0] lenNow;
	logic [7:0] winNow;
	steer_t steerNow;

	assign opt = s_r.w0[7:0];
	assign header_manipulation_field = s_r.w0[31:28];
	assign enc = s_r.encap;
	assign esnOn = opt[OPT_ESN];
	assign ipv6 = opt[OPT_IPV6];
	assign tunnel = opt[OPT_TUNNEL];

	// DF copy is only meaningful on an IPv4 tunnel outer header from the block
	assign dfcOk = !ipv6 && tunnel && opt[ENC_HDR_PDB] && opt[ENC_PREPEND];

	always_comb begin
		pdbErr = 1'b0;
		if (enc) begin
			if (header_manipulation_field[HMO_RSV_OR_ODF - 28] || (|s_r.w0[W0_RSV_MSB:W0_RSV_LSB])) begin
				pdbErr = 1'b1;
			end
			if (header_manipulation_field[HMO_DFC_OR_DFV - 28] && !dfcOk) begin
				pdbErr = 1'b1;
			end
			// a prepended header must be a whole number of words
			if (opt[ENC_PREPEND] && (s_r.hl == 8'h00 || s_r.hl[1:0] != 2'b00)) begin
				pdbErr = 1'b1;
			end
		end else if (opt[DEC_LEN_ADJ] && !opt[DEC_PDU_ONLY]) begin
			pdbErr = 1'b1;
		end
	end

	assign ttlErr = header_manipulation_field[HMO_HOP_COUNT_DECREMENT - 28] && s_r.ttl == 8'h00;

	// sequence advance; the high word joins the count only with EXTENDED_SEQ_ENABLE set
	seq_advance #(
		.W(32)
	) u_seq (
		.lowIn(s_r.lo),
		.highIn(s_r.hi),
		.useHigh(esnOn),
		.lowOut(loInc),
		.highOut(hiInc),
		.wrap(wrap)
	);

	assign seqErr = enc && wrap && !header_manipulation_field[HMO_ROLL_OR_DSC - 28];

	// block errors outrank header errors, which outrank sequence errors
	always_comb begin
		if (pdbErr) begin
			errNow = ERR_PDB;
		end else if (ttlErr) begin
			errNow = ERR_TTL;
		end else if (seqErr) begin
			errNow = ERR_SEQ;
		end else begin
			errNow = ERR_NONE;
		end
	end

	// ----------------------------------------------------------------
	// header edits
	// ----------------------------------------------------------------
	assign ttlNew = header_manipulation_field[HMO_HOP_COUNT_DECREMENT - 28] ? s_r.ttl - 8'h01 : s_r.ttl;

	always_comb begin
		dfNew = s_r.dfHdr;
		if (enc && header_manipulation_field[HMO_DFC_OR_DFV - 28]) begin
			dfNew = s_r.dfInner;
		end else if (!enc && !ipv6 && header_manipulation_field[HMO_RSV_OR_ODF - 28]) begin
			dfNew = header_manipulation_field[HMO_DFC_OR_DFV - 28];
		end
	end

	// on IPv4 the TTL always carries its checksum fix; other edits follow the option bit
	assign csOn = enc ? opt[ENC_CKSM] : opt[DEC_CKSM];
	assign ckTtl = (!ipv6 && header_manipulation_field[HMO_HOP_COUNT_DECREMENT - 28]) ?
		csAdj(s_r.ck, {s_r.ttl, 8'h00}, {ttlNew, 8'h00}) : s_r.ck;
	assign ckDf = (!ipv6 && csOn) ?
		csAdj(ckTtl, s_r.dfHdr ? DF_MASK : 16'h0000, dfNew ? DF_MASK : 16'h0000) : ckTtl;

	assign lenNow = (!enc && opt[DEC_LEN_ADJ]) ?
		16'(s_r.flen - {8'h00, s_r.pad} - TRAILER_FIXED) : s_r.flen;

	always_comb begin
		winNow = WIN_NONE;
		if (!enc) begin
			unique case (opt[DEC_WIN_LSB +: 2])
			2'b00: winNow = WIN_NONE;
			2'b01: winNow = WIN_32;
			2'b10: winNow = WIN_128;
			2'b11: winNow = WIN_64;
			endcase
		end
	end

	always_comb begin
		steerNow = '0;
		steerNow.ipv6 = ipv6;
		steerNow.tunnel = tunnel;
		steerNow.icvHighSeq = esnOn;
		steerNow.cksumOn = csOn;
		if (enc) begin
			steerNow.omitHighSeq = esnOn;
			steerNow.hdrFromPdb = opt[ENC_HDR_PDB];
			steerNow.prependHdr = opt[ENC_PREPEND];
			steerNow.ivFromRng = opt[ENC_IV_RNG];
			steerNow.dfCopied = header_manipulation_field[HMO_DFC_OR_DFV - 28];
		end else begin
			steerNow.omitHighSeq = 1'b1;
			steerNow.pduOnly = opt[DEC_PDU_ONLY];
			steerNow.lenAdjust = opt[DEC_LEN_ADJ];
			steerNow.dfForced = !ipv6 && header_manipulation_field[HMO_RSV_OR_ODF - 28];
		end
	end

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		unique case (s_r.st)
		IDLE: begin
			if (link.start) begin
				s_nxt.st = EVAL;
				s_nxt.encap = link.encap;
				s_nxt.w0 = link.pdbWord0;
				s_nxt.hi = link.highSeq;
				s_nxt.lo = link.lowSeq;
				s_nxt.fseq = link.frameSeq;
				s_nxt.ttl = link.ttlIn;
				s_nxt.dfInner = link.dfInner;
				s_nxt.dfHdr = link.dfHdr;
				s_nxt.ck = link.cksumIn;
				s_nxt.hl = link.hdrLen;
				s_nxt.flen = link.frameLen;
				s_nxt.pad = link.padLen;
				s_nxt.seqWr = 1'b0;
			end
		end
		EVAL: begin
			s_nxt.st = IDLE;
			s_nxt.done = 1'b1;
			s_nxt.err = errNow;
			s_nxt.steer = steerNow;
			s_nxt.win = winNow;
			if (errNow == ERR_NONE) begin
				s_nxt.ttlOut = ttlNew;
				s_nxt.dfOut = dfNew;
				s_nxt.ckOut = ckDf;
				s_nxt.lenOut = lenNow;
				if (enc) begin
					s_nxt.seqWr = 1'b1;
					s_nxt.loOut = loInc;
					s_nxt.hiOut = hiInc;
				end else begin
					// suite words 1 and 2 never reach this block
					s_nxt.loOut = s_r.fseq;
					s_nxt.hiOut = esnOn ? s_r.hi : 32'h0000_0000;
				end
			end else begin
				// header left untouched and nothing written back
				s_nxt.seqWr = 1'b0;
				s_nxt.ttlOut = s_r.ttl;
				s_nxt.dfOut = s_r.dfHdr;
				s_nxt.ckOut = s_r.ck;
				s_nxt.lenOut = s_r.flen;
				s_nxt.loOut = s_r.lo;
				s_nxt.hiOut = s_r.hi;
			end
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link.busy = s_r.st != IDLE;
	assign link.done = s_r.done;
	assign link.err = s_r.err;
	assign link.seqWrite = s_r.seqWr;
	assign link.highSeqOut = s_r.hiOut;
	assign link.lowSeqOut = s_r.loOut;
	assign link.ttlOut = s_r.ttlOut;
	assign link.dfOut = s_r.dfOut;
	assign link.cksumOut = s_r.ckOut;
	assign link.outLen = s_r.lenOut;
	assign link.winSize = s_r.win;
	assign link.steer = s_r.steer;
	assign pathSteer = s_r.steer;
	assign pathWin = s_r.win;
endmodule
`default_nettype wire

// >>> rtl/descriptor_exec_controller.sv
`timescale 1ns/1ps
`default_nettype none
module descriptor_exec_controller (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	ipsec_opt_if.ctl link
);
	import ipsec_opt_pkg::*;

	typedef struct packed {
		logic start;
		logic encap;
		logic doneSeen;
		err_t err;
		logic [31:0] pdb0;
		logic [31:0] hi;
		logic [31:0] lo;
		logic [31:0] fseq;
		logic [31:0] hdr;
		logic [15:0] ck;
		logic [31:0] frame;
		logic [31:0] resHdr;
		logic [31:0] resLen;
		logic [31:0] steer;
		logic [SCORE_WORDS-1:0][31:0] score;
		logic [31:0] rdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic [31:0] pdbClean;

	// ----------------------------------------------------------------
	// block word cleanup before launch
	// ----------------------------------------------------------------
	always_comb begin
		pdbClean = s_r.pdb0;
		// only read on a launch write; the direction written with it is the one that counts,
		// not the one left over from the previous job
		if (!wdata[1]) begin
			if (s_r.pdb0[OPT_IPV6]) begin
				pdbClean[HMO_RSV_OR_ODF] = 1'b0;
			end
			if (!pdbClean[HMO_RSV_OR_ODF]) begin
				pdbClean[HMO_DFC_OR_DFV] = 1'b0;
			end
			if (!s_r.pdb0[DEC_PDU_ONLY]) begin
				pdbClean[DEC_LEN_ADJ] = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		if (wr) begin
			unique case (addr)
			REG_CTRL: begin
				s_nxt.encap = wdata[1];
				// a launch while the handler is busy is dropped
				if (wdata[0] && !link.busy && !s_r.start) begin
					s_nxt.start = 1'b1;
					s_nxt.pdb0 = pdbClean;
				end
			end
			REG_PDB0: begin
				s_nxt.pdb0 = wdata;
				s_nxt.score = '0;
			end
			REG_HI_SEQ: s_nxt.hi = wdata;
			REG_LO_SEQ: s_nxt.lo = wdata;
			REG_FRAME_SEQ: s_nxt.fseq = wdata;
			REG_HDR: s_nxt.hdr = wdata;
			REG_CKSUM: s_nxt.ck = wdata[15:0];
			REG_FRAME: s_nxt.frame = wdata;
			default: begin
			end
			endcase
		end
		if (rd) begin
			if (addr == REG_STATUS) begin
				s_nxt.doneSeen = 1'b0;
			end
			unique case (addr)
			REG_CTRL: s_nxt.rdata = {30'h0, s_r.encap, 1'b0};
			REG_STATUS: s_nxt.rdata = {26'h0, s_r.err, 2'b00, s_r.doneSeen,
				link.busy | s_r.start};
			REG_PDB0: s_nxt.rdata = s_r.pdb0;
			REG_HI_SEQ: s_nxt.rdata = s_r.hi;
			REG_LO_SEQ: s_nxt.rdata = s_r.lo;
			REG_FRAME_SEQ: s_nxt.rdata = s_r.fseq;
			REG_HDR: s_nxt.rdata = s_r.hdr;
			REG_CKSUM: s_nxt.rdata = {16'h0000, s_r.ck};
			REG_FRAME: s_nxt.rdata = s_r.frame;
			REG_RES_HDR: s_nxt.rdata = s_r.resHdr;
			REG_RES_LEN: s_nxt.rdata = s_r.resLen;
			REG_STEER: s_nxt.rdata = s_r.steer;
			default: begin
				for (int i = 0; i < SCORE_WORDS; i++) begin
					if (addr == REG_SCORE0 + 8'(4 * i)) begin
						s_nxt.rdata = s_r.score[i];
					end
				end
			end
			endcase
		end
		// completion wins over a status read in the same cycle
		if (link.done) begin
			s_nxt.doneSeen = 1'b1;
			s_nxt.err = link.err;
			s_nxt.resHdr = {link.cksumOut, 7'h00, link.dfOut, link.ttlOut};
			s_nxt.resLen = {8'h00, link.winSize, link.outLen};
			s_nxt.steer = {20'h00000, link.steer};
			if (link.seqWrite) begin
				s_nxt.hi = link.highSeqOut;
				s_nxt.lo = link.lowSeqOut;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign link.start = s_r.start;
	assign link.encap = s_r.encap;
	assign link.pdbWord0 = s_r.pdb0;
	assign link.highSeq = s_r.hi;
	assign link.lowSeq = s_r.lo;
	assign link.frameSeq = s_r.fseq;
	assign link.ttlIn = s_r.hdr[7:0];
	assign link.dfInner = s_r.hdr[8];
	assign link.dfHdr = s_r.hdr[9];
	assign link.hdrLen = s_r.hdr[23:16];
	assign link.cksumIn = s_r.ck;
	assign link.frameLen = s_r.frame[15:0];
	assign link.padLen = s_r.frame[23:16];
endmodule
`default_nettype wire

// >>> dv/ipsec_opt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ipsec_opt_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic encap,
	input wire logic busy,
	input wire logic done,
	input wire ipsec_opt_pkg::err_t err,
	input wire logic seqWrite,
	input wire logic [31:0] pdbWord0,
	input wire logic [31:0] highSeq,
	input wire logic [31:0] lowSeq,
	input wire logic [31:0] frameSeq,
	input wire logic [7:0] ttlIn,
	input wire logic [15:0] frameLen,
	input wire logic [7:0] padLen,
	input wire logic [31:0] highSeqOut,
	input wire logic [31:0] lowSeqOut,
	input wire logic [7:0] ttlOut,
	input wire logic [15:0] outLen,
	input wire logic [7:0] winSize,
	input wire ipsec_opt_pkg::steer_t steer
);
	import ipsec_opt_pkg::*;
	// ------------------------------
	// job capture
	// ------------------------------
	// fields are held from the taking edge, as the link may change them before done
	logic jobEnc_r;
	logic [31:0] jobWord_r, jobHigh_r, jobLow_r, jobFrame_r;
	logic [7:0] jobTtl_r, jobPad_r;
	logic [15:0] jobLen_r;
	logic [63:0] seqNext;
	logic wrapHit;
	logic [7:0] winTab [4] = '{WIN_NONE, WIN_32, WIN_128, WIN_64};
	always_ff @(posedge clk) begin
		if (start && !busy) begin
			jobEnc_r <= encap;
			jobWord_r <= pdbWord0;
			jobHigh_r <= highSeq;
			jobLow_r <= lowSeq;
			jobFrame_r <= frameSeq;
			jobTtl_r <= ttlIn;
			jobLen_r <= frameLen;
			jobPad_r <= padLen;
		end
	end
	assign seqNext = jobWord_r[OPT_ESN] ? {jobHigh_r, jobLow_r} + 64'h1 :
		{jobHigh_r, jobLow_r + 32'h1};
	assign wrapHit = jobWord_r[OPT_ESN] ? (&jobHigh_r && &jobLow_r) : &jobLow_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_DONE_TWO: assert property (start && !busy |=> busy ##1 (done && !busy))
		else $error("answer not two cycles after start");
	AST_WIN: assert property (done && !jobEnc_r && err == ERR_NONE |->
		winSize == winTab[jobWord_r[7:6]]) else $error("replay window size wrong");
	AST_SEQ_ENC: assert property (done && jobEnc_r && err == ERR_NONE |->
		seqWrite && {highSeqOut, lowSeqOut} == seqNext) else $error("sequence writeback wrong");
	AST_WRAP_ERR: assert property (done && jobEnc_r && wrapHit && !jobWord_r[28] |->
		err != ERR_NONE && !seqWrite) else $error("forbidden rollover accepted");
	AST_DEC_SEQ: assert property (done && !jobEnc_r && err == ERR_NONE |-> !seqWrite &&
		lowSeqOut == jobFrame_r && highSeqOut == (jobWord_r[OPT_ESN] ? jobHigh_r : 32'h0))
		else $error("decap sequence words wrong");
	AST_LEN: assert property (done && !jobEnc_r && err == ERR_NONE |-> outLen ==
		(jobWord_r[DEC_LEN_ADJ] ? jobLen_r - {8'h00, jobPad_r} - TRAILER_FIXED : jobLen_r))
		else $error("output length wrong");
	AST_TTL: assert property (done && jobWord_r[HMO_HOP_COUNT_DECREMENT] && err == ERR_NONE |->
		ttlOut == jobTtl_r - 8'h01) else $error("hop count not decremented");
	AST_TTL_UNDER: assert property (done && jobWord_r[HMO_HOP_COUNT_DECREMENT] && jobTtl_r == 8'h00 |->
		err != ERR_NONE && !seqWrite) else $error("hop count underflow accepted");
	AST_MODE: assert property (done && err == ERR_NONE |-> steer.ipv6 == jobWord_r[OPT_IPV6] &&
		steer.tunnel == jobWord_r[OPT_TUNNEL]) else $error("mode steering wrong");
	AST_ENC_STEER: assert property (done && jobEnc_r && err == ERR_NONE |->
		steer.hdrFromPdb == jobWord_r[3] && steer.prependHdr == jobWord_r[2] &&
		steer.cksumOn == jobWord_r[7] && steer.ivFromRng == jobWord_r[5])
		else $error("encap steering wrong");
	AST_DEC_STEER: assert property (done && !jobEnc_r && err == ERR_NONE |->
		steer.pduOnly == jobWord_r[3] && steer.cksumOn == jobWord_r[5])
		else $error("decap steering wrong");
	AST_RSV: assert property (done && jobEnc_r && jobWord_r[27:24] != 4'h0 |->
		err == ERR_PDB) else $error("reserved bits not refused");
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ipsec_opt_pkg::*;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [31:0] rdata;
	logic [31:0] r;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] winTab [4] = '{WIN_NONE, WIN_32, WIN_128, WIN_64};
	ipsec_opt_if link();
	always #2 clk = ~clk;
	descriptor_exec_controller descriptor_exec_controller_inst (.clk(clk), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
	ipsec_esp_pdb_option_handler ipsec_esp_pdb_option_handler_inst (.clk(clk), .rstn(rstn),
		.link(link), .pathSteer(), .pathWin());
	ipsec_opt_chk ipsec_opt_chk_inst (.clk(clk), .rstn(rstn), .start(link.start),
		.encap(link.encap), .busy(link.busy), .done(link.done), .err(link.err),
		.seqWrite(link.seqWrite), .pdbWord0(link.pdbWord0), .highSeq(link.highSeq),
		.lowSeq(link.lowSeq), .frameSeq(link.frameSeq), .ttlIn(link.ttlIn),
		.frameLen(link.frameLen), .padLen(link.padLen), .highSeqOut(link.highSeqOut),
		.lowSeqOut(link.lowSeqOut), .ttlOut(link.ttlOut), .outLen(link.outLen),
		.winSize(link.winSize), .steer(link.steer));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// n above one gives back-to-back writes of the same word
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d, input int n = 1);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		repeat (n) @(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask
	function automatic logic [1:0] expErr(input logic enc, input logic [31:0] w,
			input logic [31:0] hi, input logic [31:0] lo, input logic [7:0] ttl);
		logic wrap;
		wrap = w[OPT_ESN] ? (&hi && &lo) : &lo;
		if (enc && (w[31] || w[27:24] != 4'h0)) return 2'h1;
		if (enc && w[30] && !(!w[1] && w[0] && w[3] && w[2])) return 2'h1;
		if (w[29] && ttl == 8'h00) return 2'h3;
		if (enc && wrap && !w[28]) return 2'h2;
		return 2'h0;
	endfunction
	task automatic runJob(input logic enc, input logic [31:0] w, input logic [31:0] hi,
			input logic [31:0] lo, input logic [7:0] ttl, input logic [15:0] flen,
			input logic [7:0] pad, input int launches = 1);
		logic [31:0] d;
		logic [31:0] d2;
		logic [1:0] e;
		logic [63:0] sq;
		logic [15:0] len;
		logic df;
		logic [15:0] ck;
		int n;
		wrReg(REG_PDB0, w);
		wrReg(REG_HI_SEQ, hi);
		wrReg(REG_LO_SEQ, lo);
		wrReg(REG_FRAME_SEQ, ~lo);
		wrReg(REG_HDR, {8'h00, 8'h14, 8'h00, ttl});
		wrReg(REG_FRAME, {8'h00, pad, flen});
		wrReg(REG_CTRL, {30'h0, enc, 1'h1}, launches);
		n = 0;
		d = 32'h0;
		while (d[1] !== 1'h1 && n < 16) begin
			rdReg(REG_STATUS, d);
			n++;
		end
		chk({31'h0, d[1]}, 32'h1, "done flag");
		e = expErr(enc, w, hi, lo, ttl);
		chk({30'h0, d[5:4]}, {30'h0, e}, "status error code");
		rdReg(REG_RES_HDR, d);
		df = !enc && e == 2'h0 && w[31] && !w[1] && w[30];
		ck = (e == 2'h0 && w[29] && !w[1]) ? 16'h0100 : 16'h0000;
		// a DF rise costs 0x4000 in one's complement; no end carry at these values
		if (df && w[5]) begin
			ck = ck + 16'hBFFF;
		end
		chk({31'h0, d[8]}, {31'h0, df}, "df bit");
		chk({16'h0, d[31:16]}, {16'h0, ck}, "header checksum");
		chk({24'h0, d[7:0]}, {24'h0, (e == 2'h0 && w[29]) ? ttl - 8'h01 : ttl}, "hop count");
		rdReg(REG_RES_LEN, d);
		len = (!enc && e == 2'h0 && w[2] && w[3]) ? flen - {8'h00, pad} - 16'h0002 : flen;
		chk({16'h0, d[15:0]}, {16'h0, len}, "output length");
		if (!enc && e == 2'h0) begin
			chk({24'h0, d[23:16]}, {24'h0, winTab[w[7:6]]}, "window size");
		end
		sq = w[OPT_ESN] ? {hi, lo} + 64'h1 : {hi, lo + 32'h1};
		if (!(enc && e == 2'h0)) begin
			sq = {hi, lo};
		end
		rdReg(REG_HI_SEQ, d);
		rdReg(REG_LO_SEQ, d2);
		chk(d, sq[63:32], "high sequence word");
		chk(d2, sq[31:0], "low sequence word");
		$display("test done: encap %0h word %h", enc, w);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("Error at %0t: run did not finish", $time);
			close_out();
		end
	end
	initial begin
		r = $urandom(19609);
		repeat (6) @(posedge clk);
		rstn <= 1'h1;
		// ------------------------------
		// corner cases
		// ------------------------------
		runJob(1'h1, 32'h0000_0000, 32'h5, 32'hFFFF_FFFF, 8'h40, 16'h0080, 8'h00);
		runJob(1'h1, 32'h1000_0000, 32'h5, 32'hFFFF_FFFF, 8'h40, 16'h0080, 8'h00);
		runJob(1'h1, 32'h0000_0010, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 8'h40, 16'h80, 8'h00);
		runJob(1'h1, 32'h1000_00BD, 32'h7, 32'hFFFF_FFFF, 8'h40, 16'h0080, 8'h00);
		runJob(1'h1, 32'h2000_0000, 32'h1, 32'h1, 8'h00, 16'h0080, 8'h00);
		runJob(1'h0, 32'h2000_0000, 32'h1, 32'h1, 8'h00, 16'h0080, 8'h00);
		runJob(1'h1, 32'h0300_0000, 32'h1, 32'h1, 8'h40, 16'h0080, 8'h00);
		runJob(1'h1, 32'h4000_0001, 32'h1, 32'h1, 8'h40, 16'h0080, 8'h00);
		runJob(1'h1, 32'h0000_0000, 32'h0, 32'h10, 8'h40, 16'h0080, 8'h00, 2);
		for (int i = 0; i < 4; i++) begin
			runJob(1'h0, {24'h0, i[1:0], 6'h3E}, 32'h9, 32'h3, 8'h01, 16'h0100, 8'h0E);
		end
		rdReg(8'hFC, r);
		chk(r, 32'h0, "unmapped read");
		rdReg(REG_SCORE0, r);
		chk(r, 32'h0, "scorecard word");
		// ------------------------------
		// random jobs
		// ------------------------------
		for (int i = 0; i < 40; i++) begin
			r = $urandom;
			runJob(r[31], $urandom & (r[31] ? 32'h3000_00FF : 32'hF000_00FF), $urandom,
				r[30] ? 32'hFFFF_FFFF : $urandom, {6'h0, r[1:0]}, {8'h01, r[15:8]}, r[23:16]);
		end
		close_out();
	end
endmodule
`default_nettype wire
